// File: src/fault_cond_pkg.sv
package fault_cond_pkg;

  // channel counts: index 0..3 positive supply inputs, 4 high voltage input, 5..9 dual inputs
  localparam int NUM_PRI  = 5;
  localparam int NUM_DUAL = 5;
  localparam int NUM_DET  = 10;
  localparam int LVL_W    = 8;
  localparam int CNT_W    = 12;

  // register map, byte addresses
  localparam logic [11:0] ADDR_STATUS = 12'h0100;
  localparam logic [3:0]  CH_LAST     = 4'h9;
  localparam logic [1:0]  REG_CFG     = 2'h0;
  localparam logic [1:0]  REG_THR     = 2'h1;
  localparam logic [1:0]  REG_TIME    = 2'h2;

  // configuration register fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_HYST_LSB = 2;
  localparam int CFG_RNG_LSB  = 7;
  localparam int CFG_DIG_BIT  = 9;
  localparam int CFG_EDGE_BIT = 10;
  localparam int CFG_PD_BIT   = 11;
  localparam logic [11:0] CFG_PRI_MASK  = 12'h01FF;
  localparam logic [11:0] CFG_DUAL_MASK = 12'h0E7F;

  // threshold register fields
  localparam int THR_UV_LSB = 0;
  localparam int THR_OV_LSB = 8;

  // timing register fields, both in microseconds
  localparam int TIME_GLITCH_LSB = 0;
  localparam int TIME_PULSE_LSB  = 8;
  localparam logic [14:0] TIME_MASK = 15'h7F7F;

  // status register fields
  localparam int ST_FAULT_LSB = 0;
  localparam int ST_WARN_LSB  = 10;
  localparam int ST_COND_LSB  = 15;
  localparam int ST_WANY_BIT  = 20;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // timing
  localparam int TIME_MAX_US    = 100;
  localparam int PCLK_PERIOD_NS = 40;
  localparam int NS_PER_US      = 1000;
  localparam logic [CNT_W-1:0] CYC_PER_US = CNT_W'(NS_PER_US / PCLK_PERIOD_NS);

  typedef enum logic [1:0] {
    MODE_UV  = 2'b00,
    MODE_OV  = 2'b01,
    MODE_WIN = 2'b10,
    MODE_OFF = 2'b11
  } det_mode_t;

  // microsecond code to clock cycles, codes above the maximum are clamped
  function automatic logic [CNT_W-1:0] us_to_cycles(input logic [6:0] us);
    logic [CNT_W-1:0] c;
    c = (us > 7'(TIME_MAX_US)) ? CNT_W'(TIME_MAX_US) : CNT_W'(us);
    return CNT_W'(c * CYC_PER_US);
  endfunction

endpackage

// File: src/glitch_filter.sv
`timescale 1ns/1ps

module glitch_filter (
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // filter
  input  wire logic                             din,
  input  wire logic [fault_cond_pkg::CNT_W-1:0] limit,
  output logic                                  dout
);
  import fault_cond_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic             out_q;

  // the output only moves after the input has differed for limit+1 cycles,
  // so both edges of a passing pulse see the same delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (din == out_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= limit) begin
      out_q <= din;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign dout = out_q;

endmodule // glitch_filter

// File: src/supply_fault_conditioner.sv
`timescale 1ns/1ps

// Notes on behaviour
// - undervoltage and overvoltage compares run every cycle, never gated.
// - a fault asserts on the plain threshold; hysteresis only delays clearing.
// - undervoltage clears only once level exceeds threshold plus hysteresis.
// - overvoltage clears only once level falls below threshold minus hysteresis.
// - hysteresis code is five bits, amount is span times code over 255.
// - glitch filter is the last stage, after hysteresis.
// - glitch timeout per input, 0 to 100 microseconds.
// - pulses shorter than the timeout never reach the output.
// - longer pulses pass, delayed by the programmed timeout.
// - dual inputs in analog use have only the lowest range.
// - digital-mode dual input turns its detector into a warning on its pair.
// - a warning detector shares the range of its paired primary detector.
// - warnings readable one by one, and ORed into one signal.
// - level-mode digital input follows the filtered pin level.
// - edge-mode digital input gives one pulse per transition, width 0..100 us.
// - digital inputs use the same glitch filter as the detectors.
// - conditioned digital inputs go out as sequencer condition inputs.
// - each digital-mode dual input has a pull-down enable bit.
// - each detector flags undervoltage, overvoltage, or out-of-window.
// - a dual input is either analog or digital, never both.
module supply_fault_conditioner (
  // clock and reset
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  // apb slave
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [11:0]                      paddr,
  input  wire logic [31:0]                      pwdata,
  output logic      [31:0]                      prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  // monitored levels, in threshold code units of each channel's range
  input  wire logic [fault_cond_pkg::NUM_DET-1:0][fault_cond_pkg::LVL_W-1:0] level_code,
  // dual input pins as logic levels
  input  wire logic [fault_cond_pkg::NUM_DUAL-1:0] dual_pin,
  // to the sequencing engine and pads
  output logic      [fault_cond_pkg::NUM_DET-1:0]  fault_flag,
  output logic      [fault_cond_pkg::NUM_DUAL-1:0] warning_flag,
  output logic                                     warning_any,
  output logic      [fault_cond_pkg::NUM_DUAL-1:0] condition_input,
  output logic      [fault_cond_pkg::NUM_DUAL-1:0] pulldown_en
);
  import fault_cond_pkg::*;

  logic [11:0] cfg_q  [NUM_DET];
  logic [15:0] thr_q  [NUM_DET];
  logic [14:0] time_q [NUM_DET];

  logic [NUM_DET-1:0]  uv_q;
  logic [NUM_DET-1:0]  ov_q;
  logic [NUM_DET-1:0]  det_raw;
  logic [NUM_DET-1:0]  det_filt;
  logic [LVL_W-1:0]    det_level [NUM_DET];
  logic [NUM_DUAL-1:0] dig_filt;
  logic [NUM_DUAL-1:0] dig_prev_q;
  logic [NUM_DUAL-1:0] pulse_q;
  logic [CNT_W-1:0]    pcnt_q [NUM_DUAL];
  logic [NUM_DUAL-1:0] is_dig;

  logic [NUM_DET-1:0]  fault_q;
  logic [NUM_DUAL-1:0] warn_q;
  logic                wany_q;
  logic [NUM_DUAL-1:0] cond_q;
  logic [NUM_DUAL-1:0] pd_q;
  logic [31:0]         prdata_q;
  logic                pready_q;
  logic                pslverr_q;
  logic                wr_done;

  // ------------------------------------------------------------ helpers

  function automatic logic uv_next(input logic cur, input logic [LVL_W-1:0] lvl,
                                   input logic [LVL_W-1:0] th, input logic [4:0] hy);
    logic [LVL_W:0] top;
    top = {1'b0, th} + {4'b0000, hy};
    if (!cur) return lvl < th;
    return {1'b0, lvl} <= top;
  endfunction

  function automatic logic ov_next(input logic cur, input logic [LVL_W-1:0] lvl,
                                   input logic [LVL_W-1:0] th, input logic [4:0] hy);
    logic [LVL_W:0] bot;
    bot = {1'b0, th} - {4'b0000, hy};
    if (!cur) return lvl > th;
    // a threshold below the hysteresis wraps negative: fault then holds until reprogrammed
    if (bot[LVL_W]) return 1'b1;
    return {1'b0, lvl} >= bot;
  endfunction

  // register index decode: valid, channel, register within channel
  function automatic logic addr_ok(input logic [11:0] a);
    return (a[11:8] == 4'h0) && (a[7:4] <= CH_LAST) && (a[3:2] != 2'h3)
           && (a[1:0] == 2'b00);
  endfunction

  // true when address a selects register r of channel c; the writes and
  // the range readback share this decode
  function automatic logic reg_hit(input logic [11:0] a, input int c, input logic [1:0] r);
    return addr_ok(a) && (a[7:4] == 4'(c)) && (a[3:2] == r);
  endfunction

  // --------------------------------------------------- detector front end

  always_comb begin
    for (int c = 0; c < NUM_DET; c++) begin
      det_level[c] = level_code[c];
    end
    for (int k = 0; k < NUM_DUAL; k++) begin
      is_dig[k] = cfg_q[NUM_PRI+k][CFG_DIG_BIT];
      if (is_dig[k]) begin
        // warning detector watches the paired primary input
        det_level[NUM_PRI+k] = level_code[k];
      end
    end
  end

  // the hysteresis code is in threshold steps, so the amount scales with range/255
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q <= '0;
      ov_q <= '0;
    end else begin
      for (int c = 0; c < NUM_DET; c++) begin
        // no enable: both comparators are evaluated on every edge
        uv_q[c] <= uv_next(uv_q[c], det_level[c], thr_q[c][THR_UV_LSB +: LVL_W],
                           cfg_q[c][CFG_HYST_LSB +: 5]);
        ov_q[c] <= ov_next(ov_q[c], det_level[c], thr_q[c][THR_OV_LSB +: LVL_W],
                           cfg_q[c][CFG_HYST_LSB +: 5]);
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_DET; c++) begin
      case (det_mode_t'(cfg_q[c][CFG_MODE_LSB +: 2]))
        MODE_UV:  det_raw[c] = uv_q[c];
        MODE_OV:  det_raw[c] = ov_q[c];
        MODE_WIN: det_raw[c] = uv_q[c] | ov_q[c];
        MODE_OFF: det_raw[c] = 1'b0;
        default:  det_raw[c] = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------- filters

  // every filter counts on pclk itself, so the timebase needs no enable of its own
  for (genvar c = 0; c < NUM_DET; c++) begin : g_det_filt
    glitch_filter u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (det_raw[c]),
      .limit   (us_to_cycles(time_q[c][TIME_GLITCH_LSB +: 7])),
      .dout    (det_filt[c])
    );
  end

  for (genvar k = 0; k < NUM_DUAL; k++) begin : g_dig_filt
    glitch_filter u_filt (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (dual_pin[k]),
      .limit   (us_to_cycles(time_q[NUM_PRI+k][TIME_GLITCH_LSB +: 7])),
      .dout    (dig_filt[k])
    );
  end

  // ----------------------------------------------------- digital inputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_prev_q <= '0;
      pulse_q    <= '0;
      for (int k = 0; k < NUM_DUAL; k++) begin
        pcnt_q[k] <= '0;
      end
    end else begin
      dig_prev_q <= dig_filt;
      for (int k = 0; k < NUM_DUAL; k++) begin
        if (dig_filt[k] != dig_prev_q[k]) begin
          // a transition inside a running pulse restarts it
          pulse_q[k] <= 1'b1;
          pcnt_q[k]  <= CNT_W'(1);
        end else if (pulse_q[k] &&
                     pcnt_q[k] >= us_to_cycles(time_q[NUM_PRI+k][TIME_PULSE_LSB +: 7])) begin
          pulse_q[k] <= 1'b0;
        end else if (pulse_q[k]) begin
          pcnt_q[k]  <= pcnt_q[k] + CNT_W'(1);
        end
      end
    end
  end

  // ------------------------------------------------------------ outputs

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
      warn_q  <= '0;
      wany_q  <= 1'b0;
      cond_q  <= '0;
      pd_q    <= '0;
    end else begin
      // a dual input in digital mode reports warnings only, never a fault
      fault_q[NUM_PRI-1:0] <= det_filt[NUM_PRI-1:0];
      for (int k = 0; k < NUM_DUAL; k++) begin
        fault_q[NUM_PRI+k] <= det_filt[NUM_PRI+k] & ~is_dig[k];
        warn_q[k]          <= det_filt[NUM_PRI+k] &  is_dig[k];
        if (!is_dig[k]) begin
          cond_q[k] <= 1'b0;
        end else if (cfg_q[NUM_PRI+k][CFG_EDGE_BIT]) begin
          cond_q[k] <= pulse_q[k];
        end else begin
          cond_q[k] <= dig_filt[k];
        end
        pd_q[k] <= is_dig[k] & cfg_q[NUM_PRI+k][CFG_PD_BIT];
      end
      wany_q <= |(det_filt[NUM_DET-1:NUM_PRI] & is_dig);
    end
  end

  assign fault_flag      = fault_q;
  assign warning_flag    = warn_q;
  assign warning_any     = wany_q;
  assign condition_input = cond_q;
  assign pulldown_en     = pd_q;

  // ---------------------------------------------------------- apb slave

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
    end
  end

  // a write takes effect only at the edge that completes the transfer
  assign wr_done = psel & penable & pready_q & pwrite;

  // one process per register kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_DET; c++) begin
        cfg_q[c] <= RESET_WORD[11:0];
      end
    end else if (wr_done) begin
      for (int c = 0; c < NUM_DET; c++) begin
        if (reg_hit(paddr, c, REG_CFG)) begin
          // dual inputs have no range field, their range is fixed lowest
          cfg_q[c] <= pwdata[11:0] & ((c < NUM_PRI) ? CFG_PRI_MASK : CFG_DUAL_MASK);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_DET; c++) begin
        thr_q[c] <= RESET_WORD[15:0];
      end
    end else if (wr_done) begin
      for (int c = 0; c < NUM_DET; c++) begin
        if (reg_hit(paddr, c, REG_THR)) begin
          thr_q[c] <= pwdata[15:0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NUM_DET; c++) begin
        time_q[c] <= RESET_WORD[14:0];
      end
    end else if (wr_done) begin
      for (int c = 0; c < NUM_DET; c++) begin
        if (reg_hit(paddr, c, REG_TIME)) begin
          // codes above the maximum are kept and clamped where they are used
          time_q[c] <= pwdata[14:0] & TIME_MASK;
        end
      end
    end
  end

  // read data and error are loaded in the first access cycle, so they stand at the
  // completing edge; pslverr drops right after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= RESET_WORD;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      prdata_q  <= RESET_WORD;
      pslverr_q <= 1'b0;
      if (paddr == ADDR_STATUS) begin
        if (!pwrite) begin
          prdata_q[ST_FAULT_LSB +: NUM_DET] <= fault_q;
          prdata_q[ST_WARN_LSB +: NUM_DUAL] <= warn_q;
          prdata_q[ST_COND_LSB +: NUM_DUAL] <= cond_q;
          prdata_q[ST_WANY_BIT]             <= wany_q;
        end else begin
          pslverr_q <= 1'b1;
        end
      end else if (!addr_ok(paddr)) begin
        pslverr_q <= 1'b1;
      end else if (!pwrite) begin
        for (int c = 0; c < NUM_DET; c++) begin
          if (paddr[7:4] == 4'(c)) begin
            case (paddr[3:2])
              REG_CFG:  prdata_q[11:0] <= cfg_q[c];
              REG_THR:  prdata_q[15:0] <= thr_q[c];
              REG_TIME: prdata_q[14:0] <= time_q[c];
              default:  prdata_q       <= RESET_WORD;
            endcase
          end
        end
        // a warning detector reports the range of its paired primary; this later
        // assignment fills bits that a dual input never stores
        for (int k = 0; k < NUM_DUAL; k++) begin
          if (reg_hit(paddr, NUM_PRI + k, REG_CFG) && is_dig[k]) begin
            prdata_q[CFG_RNG_LSB +: 2] <= cfg_q[k][CFG_RNG_LSB +: 2];
          end
        end
      end
    end else if (!psel || pready_q) begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule // supply_fault_conditioner

// File: verification/fault_cond_properties.sv
`timescale 1ns/1ps

module fault_cond_properties (
  // clock and reset
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  // apb
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [11:0]                          paddr,
  input wire logic [31:0]                          prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  // detector outputs
  input wire logic [fault_cond_pkg::NUM_DET-1:0]   fault_flag,
  input wire logic [fault_cond_pkg::NUM_DUAL-1:0]  warning_flag,
  input wire logic                                 warning_any
);
  import fault_cond_pkg::*;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_phase: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_status_ro: assert property (pready && pwrite && paddr == ADDR_STATUS |-> pslverr)
    else $error("status write not refused");
  a_align_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_warn_or: assert property (warning_any == (|warning_flag))
    else $error("warning_any is not the or of warnings");
  a_status_mirror: assert property (pready && !pwrite && paddr == ADDR_STATUS
    && $stable(fault_flag) && $stable(warning_flag)
    |-> prdata[14:0] == {warning_flag, fault_flag})
    else $error("status differs from flags");
  a_reset_quiet: assert property (!$past(presetn) |-> fault_flag == '0 && !pready)
    else $error("outputs active right after reset");

  c_refused: cover property (pready && pslverr);
  c_warning: cover property ($rose(warning_any));
  c_uv_clear: cover property ($fell(fault_flag[0]));
endmodule // fault_cond_properties

bind supply_fault_conditioner fault_cond_properties i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_flag(fault_flag), .warning_flag(warning_flag), .warning_any(warning_any)
);

// File: verification/supply_rail_model.sv
`timescale 1ns/1ps

module supply_rail_model (
  // clock and reset
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  // bench requests
  input  wire logic [fault_cond_pkg::NUM_DET-1:0][fault_cond_pkg::LVL_W-1:0] lvl_set,
  input  wire logic [fault_cond_pkg::NUM_DUAL-1:0]  pin_val,
  input  wire logic [fault_cond_pkg::NUM_DUAL-1:0]  pin_drv,
  input  wire logic [fault_cond_pkg::NUM_DUAL-1:0]  pulldown_en,
  // rails and pins
  output logic      [fault_cond_pkg::NUM_DET-1:0][fault_cond_pkg::LVL_W-1:0] level_code,
  output logic      [fault_cond_pkg::NUM_DUAL-1:0]  dual_pin
);
  import fault_cond_pkg::*;

  logic tog_q;

  // rails may move on any cycle, there is no quiet window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_code <= '0;
    end else begin
      level_code <= lvl_set;
    end
  end

  // an undriven pin wanders unless the weak pull-down holds it low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q    <= 1'b0;
      dual_pin <= '0;
    end else begin
      tog_q    <= ~tog_q;
      dual_pin <= (pin_drv & pin_val) | (~pin_drv & ~pulldown_en & {NUM_DUAL{tog_q}});
    end
  end
endmodule // supply_rail_model

// File: verification/supply_fault_conditioner_tb.sv
`timescale 1ns/1ps

module supply_fault_conditioner_tb;
  import fault_cond_pkg::*;

  logic                               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0]                        paddr;
  logic [31:0]                        pwdata, prdata;
  logic [NUM_DET-1:0][LVL_W-1:0]      lvl_set, level_code;
  logic [NUM_DUAL-1:0]                pin_val, pin_drv, dual_pin, warning_flag;
  logic [NUM_DUAL-1:0]                condition_input, pulldown_en;
  logic [NUM_DET-1:0]                 fault_flag;
  logic                               warning_any;
  logic [20:0]                        obs;
  int                                 errors, n_tests;

  assign obs = {warning_any, condition_input, warning_flag, fault_flag};

  always #20 pclk = ~pclk;

  supply_fault_conditioner i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .level_code(level_code), .dual_pin(dual_pin), .fault_flag(fault_flag),
    .warning_flag(warning_flag), .warning_any(warning_any),
    .condition_input(condition_input), .pulldown_en(pulldown_en)
  );

  supply_rail_model i_model (
    .pclk(pclk), .presetn(presetn), .lvl_set(lvl_set), .pin_val(pin_val),
    .pin_drv(pin_drv), .pulldown_en(pulldown_en), .level_code(level_code),
    .dual_pin(dual_pin)
  );

  task automatic final_report;
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  function automatic logic [11:0] ra(input logic [3:0] ch, input logic [1:0] r);
    return {4'h0, ch, r, 2'b00};
  endfunction

  // one apb transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] xd, input logic xe);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    check(i < 20, "no pready");
    if (i >= 20) final_report();
    check(pslverr === xe, "pslverr");
    if (!w) check(prdata === xd, "read data");
  endtask

  task automatic lvl(input int ch, input logic [7:0] v);
    @(posedge pclk);
    lvl_set[ch] <= v;
  endtask

  task automatic wait_bit(input int b, input logic v, input int lo, input int hi, input string m);
    int n;
    for (n = 0; n < hi && obs[b] !== v; n++) @(posedge pclk);
    check(n >= lo && obs[b] === v, m);
  endtask

  task automatic hold(input int b, input logic v, input int n, input string m);
    logic ok;
    ok = 1'b1;
    repeat (n) begin
      @(posedge pclk);
      if (obs[b] !== v) ok = 1'b0;
    end
    check(ok, m);
  endtask

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    lvl_set = '0;
    pin_val = '0;
    pin_drv = '1;
    errors  = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ra(0, REG_CFG), '0, 32'h0000_0000, 0);
    apb(0, ADDR_STATUS, '0, RESET_WORD, 0);
    apb(0, 12'h00A0, '0, 32'h0000_0000, 1);
    apb(1, ADDR_STATUS, 32'hFFFF_FFFF, '0, 1);
    apb(0, 12'h0002, '0, 32'h0000_0000, 1);
    apb(1, ra(5, REG_CFG), 32'h0000_0180, '0, 0);
    apb(0, ra(5, REG_CFG), '0, 32'h0000_0000, 0);
    // undervoltage, hysteresis code at its maximum
    lvl(0, 8'd140);
    apb(1, ra(0, REG_THR), 32'h0000_FF64, '0, 0);
    apb(1, ra(0, REG_CFG), 32'h0000_01FC, '0, 0);
    apb(0, ra(0, REG_CFG), '0, 32'h0000_01FC, 0);
    lvl(0, 8'd100);
    hold(0, 0, 10, "uv at threshold");
    lvl(0, 8'd99);
    wait_bit(0, 1, 1, 6, "uv set");
    lvl(0, 8'd131);
    hold(0, 1, 10, "uv released early");
    lvl(0, 8'd132);
    wait_bit(0, 0, 1, 6, "uv clear");
    // overvoltage with hysteresis 2
    lvl(1, 8'd190);
    apb(1, ra(1, REG_THR), 32'h0000_C800, '0, 0);
    apb(1, ra(1, REG_CFG), 32'h0000_0009, '0, 0);
    lvl(1, 8'd201);
    wait_bit(1, 1, 1, 6, "ov set");
    lvl(1, 8'd198);
    hold(1, 1, 10, "ov released early");
    lvl(1, 8'd197);
    wait_bit(1, 0, 1, 6, "ov clear");
    // window and off modes
    lvl(2, 8'd100);
    lvl(3, 8'd0);
    apb(1, ra(2, REG_THR), 32'h0000_9632, '0, 0);
    apb(1, ra(2, REG_CFG), 32'h0000_0002, '0, 0);
    apb(1, ra(3, REG_THR), 32'h0000_9632, '0, 0);
    apb(1, ra(3, REG_CFG), 32'h0000_0003, '0, 0);
    lvl(2, 8'd151);
    wait_bit(2, 1, 1, 6, "window high");
    lvl(2, 8'd100);
    wait_bit(2, 0, 1, 6, "window in");
    lvl(2, 8'd49);
    wait_bit(2, 1, 1, 6, "window low");
    hold(3, 0, 4, "off mode");
    // one microsecond filter on the first input
    apb(1, ra(0, REG_TIME), 32'h0000_0001, '0, 0);
    lvl(0, 8'd99);
    repeat (20) @(posedge pclk);
    lvl(0, 8'd140);
    hold(0, 0, 40, "short dip passed");
    lvl(0, 8'd99);
    wait_bit(0, 1, 25, 32, "filter delay");
    // first dual input digital with pull-down; its detector warns on rail 0
    apb(1, ra(5, REG_THR), 32'h0000_FF78, '0, 0);
    apb(1, ra(5, REG_CFG), 32'h0000_0A00, '0, 0);
    apb(0, ra(5, REG_CFG), '0, 32'h0000_0B80, 0);
    check(pulldown_en[0] === 1'b1, "pull-down enable");
    wait_bit(10, 1, 0, 8, "warning");
    wait_bit(20, 1, 0, 8, "warning or");
    check(fault_flag[5] === 1'b0, "digital input faulted");
    apb(0, ADDR_STATUS, '0, 32'h0010_0405, 0);
    @(posedge pclk) pin_val[0] <= 1'b1;
    wait_bit(15, 1, 1, 6, "level follow");
    @(posedge pclk) pin_drv[0] <= 1'b0;
    wait_bit(15, 0, 1, 6, "floating pin");
    // second dual input edge mode, filter and pulse one microsecond each
    apb(1, ra(6, REG_TIME), 32'h0000_0101, '0, 0);
    apb(1, ra(6, REG_CFG), 32'h0000_0600, '0, 0);
    @(posedge pclk) pin_val[1] <= 1'b1;
    repeat (10) @(posedge pclk);
    pin_val[1] <= 1'b0;
    hold(16, 0, 40, "bounce passed");
    @(posedge pclk) pin_val[1] <= 1'b1;
    wait_bit(16, 1, 25, 32, "edge pulse");
    wait_bit(16, 0, 24, 27, "pulse width");
    final_report();
  end
endmodule // supply_fault_conditioner_tb
